// File: bpse_regs.vh
`ifndef BPSE_REGS_VH
`define BPSE_REGS_VH

// Register byte offsets, compared against haddr[7:0]
`define BPSE_CTRL_ADDR   8'h00
`define BPSE_PAT_ADDR    8'h04
`define BPSE_STAT_ADDR   8'h08
`define BPSE_BITCNT_ADDR 8'h0C
`define BPSE_ERRCNT_ADDR 8'h10

// Control register field positions
`define BPSE_EN_BIT      0
`define BPSE_REP_BIT     1
`define BPSE_QRSS_BIT    2
`define BPSE_RSDIS_BIT   3
`define BPSE_INV_BIT     4
`define BPSE_ERRINS_BIT  5
`define BPSE_LOAD_BIT    6
`define BPSE_CLR_BIT     7
`define BPSE_TAPN_LSB    8
`define BPSE_TAPN_MSB    12
`define BPSE_TAPY_LSB    16
`define BPSE_TAPY_MSB    20

// Reset values
`define BPSE_TAPN_RST    5'h16
`define BPSE_TAPY_RST    5'h11
`define BPSE_PAT_RST     32'h00000000
`define BPSE_SEED        32'hFFFFFFFF

// Sync and monitoring figures
`define BPSE_LAST_BIT    6'h1F
`define BPSE_CNT_SAT     6'h20
`define BPSE_WIN_LAST    6'h3F
`define BPSE_RESYNC_THR  7'h06
`define BPSE_QRSS_TAPA   16
`define BPSE_QRSS_TAPB   19
`define BPSE_QRSS_ZMSB   13
`define BPSE_BITCNT_MAX  32'hFFFFFFFF
`define BPSE_ERRCNT_MAX  24'hFFFFFF

`endif

// File: bpse_bert.v
// Operation
// RQ1: Receive generator is a 32-stage register shifting toward stage 32, feedback into stage 1.
// RQ2: PRBS feedback is stage n xor stage y.
// RQ3: Repetitive feedback is stage n, so the pattern recirculates.
// RQ4: Software programs n and y separately, each 1 through 32.
// RQ5: Generator output is its feedback, compared with incoming bits.
// RQ6: QRSS feedback is stages 17 xor 20; output forced one after 14 zeros.
// RQ7: Software enable turns QRSS on or off.
// RQ8: PRBS and QRSS feedback forced one when stages 1 to 31 are zero.
// RQ9: Pattern type selects PRBS or repetitive synchronisation.
// RQ10: PRBS sync loads 32 bits, checks next 32, syncs only if all match.
// RQ11: PRBS resync starts when mismatches in a 64-bit window reach six.
// RQ12: Repetitive sync searches every bit position, then checks 32 bits all matching.
// RQ13: Repetitive resync uses the same six-in-64 threshold.
// RQ14: Software can disable automatic resynchronisation.
// RQ15: The framer drives payload gates; only gated bits are processed.
// RQ16: Pattern keeps transmitting in X.86 mode with the transmit gate as output; here tx_payload_gate stays an input and every bit is payload.
// RQ17: While active the tester replaces the normal serial data path.
// RQ18: Normal data path returns when the tester is switched off.
// RQ19: Transmit side places the pattern into outgoing payload positions.
// RQ20: Receive side extracts payload and checks it against the pattern.
// RQ21: PRBS lengths 2^9-1, 2^15-1, 2^23-1 and QRSS are supported.
// RQ22: Repetitive length 1 to 32 bits, value 0 to 2^n-1.
// RQ23: 24-bit error counter, 32-bit bit counter, single error insertion.
// RQ24: Sync lost shown whenever the sync machine is outside its sync state.
// RQ25: Counters count checked bits and mismatches, frozen while out of sync.
// RQ26: Resync returns to load or search and reports sync lost until relock.
//
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`include "bpse_regs.vh"

module bpse_bert (
  input  wire        ref_clk,
  input  wire        rst_b,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [31:0] hrdata,
  input  wire        rxData,
  input  wire        rx_payload_gate,
  input  wire        tx_payload_gate,
  input  wire        x86Mode,
  input  wire        normTxData,
  output reg         txData,
  output reg         normRxData,
  output reg         sync_lost
);

  // Sync machine states, one-hot
  localparam [2:0] ST_LOAD  = 3'b001;
  localparam [2:0] ST_CHECK = 3'b010;
  localparam [2:0] ST_SYNC  = 3'b100;

  // Feedback of a 32-stage generator; stage k is bit k-1
  function fbCalc;
    input [31:0] g;
    input [4:0]  n;
    input [4:0]  y;
    input        rep;
    input        qrss;
    reg          f;
    begin
      if (rep) begin
        f = g[n]; // RQ3
      end else if (qrss) begin
        f = g[`BPSE_QRSS_TAPA] ^ g[`BPSE_QRSS_TAPB]; // RQ6
      end else begin
        f = g[n] ^ g[y]; // RQ2
      end
      // Lock-up guard only; a repetitive pattern may be all zero
      if (!rep && (g[30:0] == 31'h00000000)) begin
        f = 1'b1; // RQ8
      end
      fbCalc = f;
    end
  endfunction

  // Generator output: the feedback, with the QRSS zero-run limit
  function outCalc;
    input [31:0] g;
    input [4:0]  n;
    input [4:0]  y;
    input        rep;
    input        qrss;
    begin
      outCalc = fbCalc(g, n, y, rep, qrss); // RQ5
      if (!rep && qrss && (g[`BPSE_QRSS_ZMSB:0] == 14'h0000)) begin
        outCalc = 1'b1; // RQ6
      end
    end
  endfunction

  // Pin inputs from the line side: two-stage synchronisers
  // Limitation: a pin pulse shorter than one clock may be missed
  reg  [4:0]  pinMeta_reg;
  reg  [4:0]  pinSync_reg;
  wire        rxBit   = pinSync_reg[0];
  wire        rxGate  = pinSync_reg[1];
  wire        txGate  = pinSync_reg[2];
  wire        x86Sync = pinSync_reg[3];
  wire        normTx  = pinSync_reg[4];

  always @(posedge ref_clk) begin
    if (!rst_b) begin
      pinMeta_reg <= 5'h00;
      pinSync_reg <= 5'h00;
    end else begin
      pinMeta_reg <= {normTxData, x86Mode, tx_payload_gate, rx_payload_gate, rxData};
      pinSync_reg <= pinMeta_reg;
    end
  end

  // Control and configuration
  reg         enable_reg;
  reg         repMode_reg;
  reg         qrss_reg;
  reg         resyncDis_reg;
  reg         invert_reg;
  reg  [4:0]  tapN_reg;
  reg  [4:0]  tapY_reg;
  reg  [31:0] pattern_reg;
  reg         enPrev_reg;
  reg         wrPend_reg;
  reg  [7:0]  wrAddr_reg;
  reg         loadPend_reg;

  // AHB-Lite: address phase taken when selected, NONSEQ/SEQ and ready
  wire busTake = hsel & htrans[1] & hready;
  wire ctrlWr  = wrPend_reg && (wrAddr_reg == `BPSE_CTRL_ADDR);
  // Self-clearing command bits act only during the write data phase
  wire errInsReq = ctrlWr & hwdata[`BPSE_ERRINS_BIT];
  wire loadReq   = ctrlWr & hwdata[`BPSE_LOAD_BIT];
  wire cntClrReq = ctrlWr & hwdata[`BPSE_CLR_BIT];
  // Reload waits a cycle so a mode written with it is already in place
  wire restart   = loadPend_reg | (enable_reg & ~enPrev_reg);

  reg  [2:0]  state_reg;
  reg  [5:0]  bitIdx_reg;
  reg  [5:0]  winCnt_reg;
  reg  [6:0]  errWin_reg;
  reg  [31:0] rxGen_reg;
  reg  [31:0] bitCnt_reg;
  reg  [23:0] errCnt_reg;
  reg  [31:0] txGen_reg;
  reg         errPend_reg;

  // Register writes land in the data phase; always OKAY, zero wait
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      wrPend_reg    <= 1'b0;
      wrAddr_reg    <= 8'h00;
      enable_reg    <= 1'b0;
      repMode_reg   <= 1'b0;
      qrss_reg      <= 1'b0;
      resyncDis_reg <= 1'b0;
      invert_reg    <= 1'b0;
      tapN_reg      <= `BPSE_TAPN_RST;
      tapY_reg      <= `BPSE_TAPY_RST;
      pattern_reg   <= `BPSE_PAT_RST;
      enPrev_reg    <= 1'b0;
      loadPend_reg  <= 1'b0;
      hreadyout     <= 1'b1;
      hresp         <= 1'b0;
    end else begin
      wrPend_reg <= busTake & hwrite;
      wrAddr_reg <= haddr[7:0];
      enPrev_reg <= enable_reg;
      loadPend_reg <= loadReq;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      if (ctrlWr) begin
        enable_reg    <= hwdata[`BPSE_EN_BIT]; // RQ17
        repMode_reg   <= hwdata[`BPSE_REP_BIT]; // RQ9
        qrss_reg      <= hwdata[`BPSE_QRSS_BIT]; // RQ7
        resyncDis_reg <= hwdata[`BPSE_RSDIS_BIT]; // RQ14
        invert_reg    <= hwdata[`BPSE_INV_BIT];
        tapN_reg      <= hwdata[`BPSE_TAPN_MSB:`BPSE_TAPN_LSB]; // RQ4
        tapY_reg      <= hwdata[`BPSE_TAPY_MSB:`BPSE_TAPY_LSB]; // RQ4
      end
      if (wrPend_reg && (wrAddr_reg == `BPSE_PAT_ADDR)) begin
        pattern_reg <= hwdata; // RQ22
      end
    end
  end

  // Read data is sampled in the address phase and shown in the data phase
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      hrdata <= 32'h00000000;
    end else if (busTake && !hwrite) begin
      case (haddr[7:0])
        `BPSE_CTRL_ADDR: begin
          // Command bits are self-clearing and read as zero
          hrdata <= {11'h000, tapY_reg, 3'h0, tapN_reg, 3'h0, invert_reg,
                     resyncDis_reg, qrss_reg, repMode_reg, enable_reg};
        end
        `BPSE_PAT_ADDR: begin
          hrdata <= pattern_reg;
        end
        `BPSE_STAT_ADDR: begin
          // State bits let software follow the sync machine
          hrdata <= {27'h0000000, errPend_reg, state_reg, sync_lost};
        end
        `BPSE_BITCNT_ADDR: begin
          hrdata <= bitCnt_reg;
        end
        `BPSE_ERRCNT_ADDR: begin
          hrdata <= {8'h00, errCnt_reg};
        end
        default: begin
          hrdata <= 32'h00000000;
        end
      endcase
    end
  end

  // Receive side: only gated bits are checked while enabled
  wire        rxBitV   = enable_reg & rxGate; // RQ15 RQ20
  wire        rxCmp    = rxBit ^ invert_reg;
  wire        rxFb     = fbCalc(rxGen_reg, tapN_reg, tapY_reg, repMode_reg, qrss_reg);
  wire        rxOut    = outCalc(rxGen_reg, tapN_reg, tapY_reg, repMode_reg, qrss_reg);
  wire        mismatch = rxOut ^ rxCmp; // RQ5
  wire [31:0] loadGen  = {rxGen_reg[30:0], rxCmp};
  // Mask of the low n stages; tapN holds n-1
  wire [31:0] repMask  = `BPSE_SEED >> (5'h1F - tapN_reg);
  wire        repHit   = (bitIdx_reg >= {1'b0, tapN_reg}) &&
                         (((loadGen ^ pattern_reg) & repMask) == 32'h00000000);
  // Seven bits hold up to 64 errors of one window
  wire [6:0]  errSum   = errWin_reg + {6'h00, mismatch};
  wire        resync   = (errSum >= `BPSE_RESYNC_THR) & ~resyncDis_reg; // RQ11 RQ13 RQ14
  wire [5:0]  bitIdxUp = bitIdx_reg + 6'h01;

  // Sync state machine and receive generator
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      state_reg  <= ST_LOAD;
      bitIdx_reg <= 6'h00;
      winCnt_reg <= 6'h00;
      errWin_reg <= 7'h00;
      rxGen_reg  <= `BPSE_SEED;
    end else if (!enable_reg || restart) begin
      state_reg  <= ST_LOAD;
      bitIdx_reg <= 6'h00;
      winCnt_reg <= 6'h00;
      errWin_reg <= 7'h00;
    end else if (rxBitV) begin
      case (state_reg)
        ST_LOAD: begin
          // The search slides one bit at a time, so every position is tried
          rxGen_reg <= loadGen; // RQ1
          if (bitIdx_reg != `BPSE_CNT_SAT) begin
            bitIdx_reg <= bitIdxUp;
          end
          if (repMode_reg) begin
            if (repHit) begin // RQ12
              state_reg  <= ST_CHECK;
              bitIdx_reg <= 6'h00;
            end
          end else if (bitIdx_reg == `BPSE_LAST_BIT) begin // RQ10
            state_reg  <= ST_CHECK;
            bitIdx_reg <= 6'h00;
          end
        end
        ST_CHECK: begin
          rxGen_reg <= {rxGen_reg[30:0], rxFb}; // RQ1
          if (mismatch) begin // RQ10 RQ12
            state_reg  <= ST_LOAD;
            bitIdx_reg <= 6'h00;
          end else if (bitIdx_reg == `BPSE_LAST_BIT) begin
            state_reg  <= ST_SYNC;
            bitIdx_reg <= 6'h00;
            winCnt_reg <= 6'h00;
            errWin_reg <= 7'h00;
          end else begin
            bitIdx_reg <= bitIdxUp;
          end
        end
        ST_SYNC: begin
          rxGen_reg  <= {rxGen_reg[30:0], rxFb};
          winCnt_reg <= winCnt_reg + 6'h01;
          // Window error count includes the current bit
          if (resync) begin // RQ26
            state_reg  <= ST_LOAD;
            bitIdx_reg <= 6'h00;
            errWin_reg <= 7'h00;
          end else if (winCnt_reg == `BPSE_WIN_LAST) begin
            errWin_reg <= 7'h00;
          end else begin
            errWin_reg <= errSum;
          end
        end
        default: begin
          state_reg  <= ST_LOAD;
          bitIdx_reg <= 6'h00;
        end
      endcase
    end
  end

  // Sync-lost flag follows the state one cycle later
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      sync_lost <= 1'b1;
    end else begin
      sync_lost <= (state_reg != ST_SYNC); // RQ24 RQ26
    end
  end

  // Counters: checked bits only in sync, saturating; clear loses no event
  wire inSyncBit = rxBitV & (state_reg == ST_SYNC) & ~restart;
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      bitCnt_reg <= 32'h00000000;
      errCnt_reg <= 24'h000000;
    end else if (cntClrReq) begin
      bitCnt_reg <= {31'h00000000, inSyncBit};
      errCnt_reg <= {23'h000000, inSyncBit & mismatch};
    end else if (inSyncBit) begin
      // Both counters hold at full scale instead of wrapping
      if (bitCnt_reg != `BPSE_BITCNT_MAX) begin
        bitCnt_reg <= bitCnt_reg + 32'h00000001; // RQ25 RQ23
      end
      if (mismatch && (errCnt_reg != `BPSE_ERRCNT_MAX)) begin
        errCnt_reg <= errCnt_reg + 24'h000001; // RQ25 RQ23
      end
    end
  end

  // Transmit side; X.86 mode drives its own gate, so every bit is payload
  // Hazard: changing x86Mode while testing shifts the bit alignment
  wire txBitV = enable_reg & (txGate | x86Sync); // RQ16 RQ15
  wire txFb   = fbCalc(txGen_reg, tapN_reg, tapY_reg, repMode_reg, qrss_reg);
  wire txOut  = outCalc(txGen_reg, tapN_reg, tapY_reg, repMode_reg, qrss_reg)
                ^ errPend_reg ^ invert_reg;

  // Generator seeded with ones for PRBS, with the pattern when repetitive
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      txGen_reg   <= `BPSE_SEED;
      errPend_reg <= 1'b0;
    end else begin
      if (restart) begin
        txGen_reg <= repMode_reg ? pattern_reg : `BPSE_SEED; // RQ21 RQ22
      end else if (txBitV) begin
        txGen_reg <= {txGen_reg[30:0], txFb}; // RQ19
      end
      // A new request in the cycle one is used stays pending
      errPend_reg <= (errPend_reg & ~(txBitV & ~restart)) | errInsReq; // RQ23
    end
  end

  // Data path mux; idle ones fill non-payload slots while testing
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      txData     <= 1'b1;
      normRxData <= 1'b1;
    end else if (enable_reg) begin
      // Ones in the gaps keep the line at its idle level
      txData     <= txBitV ? txOut : 1'b1; // RQ17 RQ19
      normRxData <= 1'b1; // RQ17
    end else begin
      txData     <= normTx; // RQ18
      normRxData <= rxBit; // RQ18
    end
  end

endmodule

// File: bpse_bert_props.sv
`timescale 1ns/1ps
`include "bpse_regs.vh"

module bpse_bert_props (
  input wire        ref_clk,
  input wire        rst_b,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire [31:0] hrdata,
  input wire        rxData,
  input wire        rx_payload_gate,
  input wire        tx_payload_gate,
  input wire        x86Mode,
  input wire        normTxData,
  input wire        txData,
  input wire        normRxData,
  input wire        sync_lost
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic       wrPh;
  logic [7:0] wrAddr;
  logic       enReg;
  logic       repReg;
  logic [6:0] gateCnt;
  // Shadow of enable and mode; gates counted at the pin run a little ahead
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      wrPh    <= 1'h0;
      enReg   <= 1'h0;
      repReg  <= 1'h0;
      gateCnt <= 7'h0;
    end else begin
      wrPh   <= hsel && htrans[1] && hready && hwrite;
      wrAddr <= haddr[7:0];
      if (wrPh && wrAddr == `BPSE_CTRL_ADDR) begin
        enReg  <= hwdata[0];
        repReg <= hwdata[1];
      end
      if (!enReg)
        gateCnt <= 7'h0;
      else if (rx_payload_gate && gateCnt != 7'h7F)
        gateCnt <= gateCnt + 7'h1;
    end
  end
  sequence s_rdTaken;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence s_offLong;
    (!enReg)[*6];
  endsequence
  a_ready_high: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp) else $error("hresp not OKAY");
  a_rdata_hold: assert property (!(hsel && htrans[1] && hready && !hwrite)
    |=> $stable(hrdata)) else $error("hrdata moved without read");
  a_unmapped_zero: assert property (s_rdTaken ##0 (haddr[7:0] == 8'h14)
    |=> hrdata == 32'h0) else $error("unmapped read not zero");
  a_idle_slot: assert property (enReg[*6] ##0
    (!$past(tx_payload_gate, 3) && !$past(x86Mode, 3)) |-> txData)
    else $error("unused slot not one");
  a_bypass_tx: assert property (s_offLong |-> txData == $past(normTxData, 3))
    else $error("normal tx path not restored");
  a_bypass_rx: assert property (s_offLong |-> normRxData == $past(rxData, 3))
    else $error("normal rx path not restored");
  a_norm_held: assert property (enReg[*3] |-> normRxData)
    else $error("normal rx path not halted");
  a_lost_off: assert property ((!enReg)[*3] |-> sync_lost)
    else $error("in sync while disabled");
  a_sync_bits: assert property ($fell(sync_lost)
    |-> gateCnt >= (repReg ? 7'h1E : 7'h3C)) else $error("sync too early");
endmodule

bind bpse_bert bpse_bert_props bpse_bert_props_inst (.ref_clk, .rst_b, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .rxData,
  .rx_payload_gate, .tx_payload_gate, .x86Mode, .normTxData, .txData, .normRxData,
  .sync_lost);

// File: bpse_line_model.sv
`timescale 1ns/1ps

module bpse_line_model (
  input wire logic  ref_clk,
  input wire logic  rst_b,
  input wire logic  txData,
  input wire logic  allSlots,
  input wire logic  corrupt,
  output logic      rxData,
  output logic      txGate,
  output logic      rxGate
);
  logic [1:0] phase = 2'h0;
  logic [2:0] gateDly = 3'h0;
  // One slot in four is overhead, so gating is exercised on both sides
  always @(posedge ref_clk) begin
    phase   <= rst_b ? phase + 2'h1 : 2'h0;
    gateDly <= {gateDly[1:0], txGate | allSlots};
  end
  // Receive gate trails by the transmit latency so payload lines up
  assign txGate = (phase != 2'h3);
  assign rxGate = gateDly[2];
  // Loopback; corrupt inverts every bit on the line
  assign rxData = txData ^ corrupt;
endmodule

// File: tb_bpse_bert.sv
`timescale 1ns/1ps
`include "bpse_regs.vh"

module tb_bpse_bert;
  logic        ref_clk = 1'h0;
  logic        rst_b = 1'h0;
  logic        hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic        x86Mode = 1'h0;
  logic        normTxData = 1'h1;
  logic        corrupt = 1'h0;
  wire         hready;
  wire  [31:0] hrdata;
  wire         rxData;
  wire         rxGate;
  wire         txGate;
  wire         txData;
  wire         normRxData;
  wire         sync_lost;
  int          failures = 0;
  int          n_checks = 0;
  logic [31:0] rd;
  logic [31:0] rd2;
  // PRBS9, PRBS15 in X.86, QRSS, repeat 8, repeat 32, PRBS23
  localparam logic [31:0] CTRL [6] = '{32'h00040801, 32'h000D0E01,
    32'h00111605, 32'h00000703, 32'h00001F03, 32'h00111601};
  localparam logic [31:0] PAT [6] = '{32'h0, 32'h0, 32'h0, 32'h000000A5,
    32'hDEADBEEF, 32'h0};

  bpse_bert bpse_bert_inst (.ref_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready, .hreadyout(hready), .hresp(), .hrdata, .rxData,
    .rx_payload_gate(rxGate), .tx_payload_gate(txGate), .x86Mode, .normTxData,
    .txData, .normRxData, .sync_lost);
  bpse_line_model bpse_line_model_inst (.ref_clk, .rst_b, .txData, .allSlots(x86Mode),
    .corrupt, .rxData, .txGate, .rxGate);

  always #4 ref_clk = ~ref_clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One single transfer; waits on hready in both phases
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel   <= 1'h1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge ref_clk);
    while (hready !== 1'h1) @(posedge ref_clk);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hready !== 1'h1) @(posedge ref_clk);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, q);
    chk(q, exp);
  endtask

  // Bounded wait; the caller judges the level reached
  task automatic waitLost(input logic v, input int lim);
    for (int i = 0; i < lim && sync_lost !== v; i++) @(posedge ref_clk);
  endtask

  task automatic t_reset();
    rdChk(`BPSE_CTRL_ADDR, 32'h00111600);
    rdChk(`BPSE_PAT_ADDR, 32'h0);
    wr(`BPSE_STAT_ADDR, 32'hFFFFFFFF);
    rdChk(`BPSE_STAT_ADDR, 32'h3);
    rdChk(8'h14, 32'h0);
    normTxData <= 1'h0;
    repeat (8) @(posedge ref_clk);
    chk({31'h0, txData}, 32'h0);
    chk({31'h0, normRxData}, 32'h0);
    normTxData <= 1'h1;
  endtask

  task automatic t_modes();
    for (int i = 0; i < 6; i++) begin
      wr(`BPSE_CTRL_ADDR, 32'h0);
      x86Mode <= (i == 1);
      wr(`BPSE_PAT_ADDR, PAT[i]);
      wr(`BPSE_CTRL_ADDR, CTRL[i]);
      waitLost(1'h0, 400);
      chk({31'h0, sync_lost}, 32'h0);
      rdChk(`BPSE_STAT_ADDR, 32'h8);
      rdChk(`BPSE_ERRCNT_ADDR, 32'h0);
      chk({31'h0, normRxData}, 32'h1);
    end
  endtask

  task automatic t_errins();
    bus(1'h0, `BPSE_BITCNT_ADDR, 32'h0, rd);
    wr(`BPSE_CTRL_ADDR, 32'h00111621);
    repeat (30) @(posedge ref_clk);
    rdChk(`BPSE_ERRCNT_ADDR, 32'h1);
    bus(1'h0, `BPSE_BITCNT_ADDR, 32'h0, rd2);
    chk({31'h0, rd2 > rd}, 32'h1);
    chk({31'h0, sync_lost}, 32'h0);
  endtask

  task automatic t_resync();
    wr(`BPSE_CTRL_ADDR, 32'h00111609);
    corrupt <= 1'h1;
    repeat (100) @(posedge ref_clk);
    chk({31'h0, sync_lost}, 32'h0);
    bus(1'h0, `BPSE_ERRCNT_ADDR, 32'h0, rd);
    chk({31'h0, rd > 32'h20}, 32'h1);
    wr(`BPSE_CTRL_ADDR, 32'h00111601);
    waitLost(1'h1, 20);
    chk({31'h0, sync_lost}, 32'h1);
    bus(1'h0, `BPSE_BITCNT_ADDR, 32'h0, rd);
    bus(1'h0, `BPSE_BITCNT_ADDR, 32'h0, rd2);
    chk(rd2, rd);
    corrupt <= 1'h0;
    waitLost(1'h0, 400);
    chk({31'h0, sync_lost}, 32'h0);
  endtask

  // Invert, counter clear and reload, all on PRBS23
  task automatic t_ctrl();
    wr(`BPSE_CTRL_ADDR, 32'h00111611);
    repeat (30) @(posedge ref_clk);
    wr(`BPSE_CTRL_ADDR, 32'h00111691);
    repeat (30) @(posedge ref_clk);
    rdChk(`BPSE_CTRL_ADDR, 32'h00111611);
    rdChk(`BPSE_ERRCNT_ADDR, 32'h0);
    chk({31'h0, sync_lost}, 32'h0);
    wr(`BPSE_CTRL_ADDR, 32'h00111651);
    waitLost(1'h1, 20);
    chk({31'h0, sync_lost}, 32'h1);
    waitLost(1'h0, 400);
    chk({31'h0, sync_lost}, 32'h0);
    rdChk(`BPSE_STAT_ADDR, 32'h8);
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'h1;
    @(posedge ref_clk);
    t_reset();
    t_modes();
    t_errins();
    t_resync();
    t_ctrl();
    finish_test();
  end

  // Whole run needs about a thousand cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    finish_test();
  end
endmodule
